/* logic/ais_input_select.sv */
`timescale 1ns/10ps
`include "ais_params.svh"

module ais_input_select
    import ais_pkg::*;
#(
    parameter logic [`AIS_CNT_W-1:0] TRACK_EDGE = `AIS_TRACK_EDGE
) (
    // System clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // Converter link
    input wire logic converter_serial_clock_i,
    input wire logic cs_n_i,
    // Configuration pins
    input wire logic input_config_select_i,
    input wire logic channel_addr_bit0_i,
    input wire logic channel_addr_bit1_i,
    input wire logic channel_addr_bit2_i,
    input wire logic range_select_i,
    // Multiplexer steering, same on both converters
    output logic [`AIS_SEL_W-1:0] vin_pos_sel_o,
    output logic [`AIS_SEL_W-1:0] vin_neg_sel_o,
    output logic vin_neg_ground_o,
    output logic addr_invalid_o,
    // Mode and output coding
    output logic [1:0] input_mode_o,
    output logic range_high_o,
    output logic twos_complement_o,
    output logic [1:0] lsb_shift_o,
    // Conversion status
    output logic track_mode_o,
    output logic acq_restart_o,
    output logic conv_corrupt_o
);

    // ----------------------------------------
    // Elaboration check
    // ----------------------------------------
    // The link counter needs at least two edges and must not wrap
    if (TRACK_EDGE < 4'h2) begin : g_bad_edge
        $error("TRACK_EDGE must be at least two");
    end

    // ----------------------------------------
    // Decode helpers
    // ----------------------------------------
    // Input wiring from the config pin and the lowest address bit
    function automatic ais_mode_t decode_mode(input logic single, input logic addr0);
        if (single) begin
            decode_mode = ais_mode_single;
        end else if (addr0) begin
            decode_mode = ais_mode_pseudo_diff;
        end else begin
            decode_mode = ais_mode_full_diff;
        end
    endfunction

    // LSB size; pseudo differential spans like a single input
    function automatic logic [1:0] lsb_of(input ais_mode_t mode, input logic high);
        if (mode == ais_mode_full_diff) begin
            lsb_of = high ? `AIS_SHIFT_DIFF_HIGH : `AIS_SHIFT_DIFF_LOW;
        end else begin
            lsb_of = high ? `AIS_SHIFT_SE_HIGH : `AIS_SHIFT_SE_LOW;
        end
    endfunction

    // Twos complement unless a unipolar input on the low span
    function automatic logic twos_of(input ais_mode_t mode, input logic high);
        twos_of = (mode == ais_mode_full_diff) || high;
    endfunction

    // ----------------------------------------
    // Link domain: serial clock edge count
    // ----------------------------------------
    logic [`AIS_CNT_W-1:0] edge_cnt_reg; // Rising edges since select fell
    logic track_back_reg; // Hold released for this frame

    // The serial clock may stop once select rises, so select high clears
    // the count directly instead of waiting for an edge that never comes
    always_ff @(posedge converter_serial_clock_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            edge_cnt_reg <= '0;
        end else if (edge_cnt_reg != TRACK_EDGE) begin
            edge_cnt_reg <= edge_cnt_reg + 4'h1;
        end
    end

    // Track flag rises on the counted edge and holds until select rises
    always_ff @(posedge converter_serial_clock_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            track_back_reg <= 1'b0;
        end else if (edge_cnt_reg == TRACK_EDGE - 4'h1) begin
            track_back_reg <= 1'b1;
        end
    end

    // ----------------------------------------
    // Crossing into the system clock
    // ----------------------------------------
    logic [6:0] pins_s; // Settled copies of every outside level
    logic cs_n_s; // Chip select, settled
    logic track_back_s; // Hold released, settled
    logic cfg_single_s; // Config pin, settled
    logic [2:0] addr_s; // Channel address, settled
    logic range_s; // Span pin, settled

    // All levels share one three-stage filter; each bit settles alone
    ais_pin_sync #(
        .WIDTH(7),
        .RESET_VAL(`AIS_SYNC_RESET)
    ) u_pin_sync (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .async_i({cs_n_i, track_back_reg, input_config_select_i,
                  channel_addr_bit2_i, channel_addr_bit1_i, channel_addr_bit0_i,
                  range_select_i}),
        .sync_o(pins_s)
    );

    assign cs_n_s = pins_s[6];
    assign track_back_s = pins_s[5];
    assign cfg_single_s = pins_s[4];
    assign addr_s = pins_s[3:1];
    assign range_s = pins_s[0];

    // ----------------------------------------
    // Live decode of the configuration pins
    // ----------------------------------------
    ais_mode_t mode_now; // Wiring the pins ask for right now
    ais_mode_t mode_reg; // Wiring applied last cycle
    logic cfg_single_reg; // Config pin as applied last cycle
    logic addr_bad; // Address outside the decode table
    logic [`AIS_SEL_W-1:0] pos_next; // Plus input index
    logic [`AIS_SEL_W-1:0] neg_next; // Minus input index

    // Address decode, no history: any change is obeyed at once
    always_comb begin
        mode_now = decode_mode(cfg_single_s, addr_s[0]);
        addr_bad = 1'b0;
        pos_next = `AIS_SEL_IDLE;
        neg_next = `AIS_SEL_IDLE;
        if (cfg_single_s) begin
            // Address is the input number less one
            if (addr_s > `AIS_LAST_SE_ADDR) begin
                addr_bad = 1'b1;
            end else begin
                pos_next = addr_s;
            end
        end else begin
            // Upper bits pick a pair, even input on the minus side
            if (addr_s[2:1] > `AIS_LAST_PAIR) begin
                addr_bad = 1'b1;
            end else begin
                pos_next = {addr_s[2:1], 1'b0};
                neg_next = {addr_s[2:1], 1'b1};
            end
        end
    end

    // ----------------------------------------
    // Track-and-hold phase
    // ----------------------------------------
    ais_phase_t phase_reg; // Current phase
    logic mode_changed; // Wiring moved since last cycle
    logic restart_hit; // Address alone moved the wiring mid-conversion
    logic corrupt_hit; // Config pin moved mid-conversion
    logic cs_n_prev_reg; // Settled select one cycle back, for its falling edge

    assign mode_changed = (mode_now != mode_reg);
    assign corrupt_hit = (phase_reg == ais_ph_convert) && (cfg_single_s != cfg_single_reg);
    assign restart_hit = (phase_reg == ais_ph_convert) && mode_changed && !corrupt_hit;

    // Phase walk; conversions abort when select rises early
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            phase_reg <= ais_ph_track;
        end else begin
            unique case (phase_reg)
                ais_ph_track: begin
                    // Only a falling select starts a frame: select and the hold flag settle apart
                    if (!cs_n_s && cs_n_prev_reg) begin
                        phase_reg <= ais_ph_convert;
                    end
                end
                ais_ph_convert: begin
                    if (cs_n_s || track_back_s) begin
                        phase_reg <= ais_ph_track;
                    end else if (restart_hit) begin
                        phase_reg <= ais_ph_reacquire;
                    end
                end
                ais_ph_reacquire: begin
                    // Acquiring again until this frame ends
                    if (cs_n_s || track_back_s) begin
                        phase_reg <= ais_ph_track;
                    end
                end
                default: begin
                    phase_reg <= ais_ph_track;
                end
            endcase
        end
    end

    // History of the applied wiring for change detection
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            mode_reg <= ais_mode_full_diff;
            cfg_single_reg <= 1'b0;
            cs_n_prev_reg <= 1'b1;
        end else begin
            mode_reg <= mode_now;
            cfg_single_reg <= cfg_single_s;
            cs_n_prev_reg <= cs_n_s;
        end
    end

    // ----------------------------------------
    // Span latch
    // ----------------------------------------
    logic range_lat_reg; // Span frozen at conversion start

    // Span is caught when a frame starts; the pin may move after the
    // third falling edge, which is well after this sample point
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            range_lat_reg <= 1'b0;
        end else if (phase_reg == ais_ph_track) begin
            range_lat_reg <= range_s;
        end
    end

    // ----------------------------------------
    // Registered outputs
    // ----------------------------------------
    // Steering follows the pins every cycle
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            vin_pos_sel_o <= `AIS_SEL_IDLE;
            vin_neg_sel_o <= `AIS_SEL_IDLE;
            vin_neg_ground_o <= 1'b0;
            addr_invalid_o <= 1'b0;
        end else begin
            vin_pos_sel_o <= pos_next;
            vin_neg_sel_o <= neg_next;
            vin_neg_ground_o <= cfg_single_s;
            addr_invalid_o <= addr_bad;
        end
    end

    // Mode, span and coding move together so they are never split
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            input_mode_o <= ais_mode_full_diff;
            range_high_o <= 1'b0;
            twos_complement_o <= 1'b1;
            lsb_shift_o <= `AIS_SHIFT_DIFF_LOW;
        end else begin
            input_mode_o <= mode_now;
            range_high_o <= range_lat_reg;
            twos_complement_o <= twos_of(mode_now, range_lat_reg);
            lsb_shift_o <= lsb_of(mode_now, range_lat_reg);
        end
    end

    // Status pulses and the track level
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            track_mode_o <= 1'b1;
            acq_restart_o <= 1'b0;
            conv_corrupt_o <= 1'b0;
        end else begin
            track_mode_o <= (phase_reg != ais_ph_convert);
            acq_restart_o <= restart_hit;
            conv_corrupt_o <= corrupt_hit;
        end
    end

    // ----------------------------------------
    // Checks, link domain
    // ----------------------------------------
    track_edge_a: assert property (@(posedge converter_serial_clock_i) disable iff (cs_n_i)
        edge_cnt_reg == TRACK_EDGE - 4'h1 |=> track_back_reg)
        else $error("hold not released on the counted edge");

    hold_early_a: assert property (@(posedge converter_serial_clock_i) disable iff (cs_n_i)
        edge_cnt_reg < TRACK_EDGE - 4'h1 |=> !track_back_reg)
        else $error("hold released too early");

    // ----------------------------------------
    // Checks, system domain
    // ----------------------------------------
    frame_start_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        phase_reg == ais_ph_track && !cs_n_s && cs_n_prev_reg |=>
        phase_reg == ais_ph_convert ##1 !track_mode_o)
        else $error("frame start missed");

    diff_pair_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        !cfg_single_s && addr_s[2:1] <= `AIS_LAST_PAIR |=>
        !vin_neg_ground_o && vin_neg_sel_o == {$past(addr_s[2:1]), 1'b1}
        && vin_pos_sel_o == {$past(addr_s[2:1]), 1'b0})
        else $error("differential pair steering wrong");

    single_sel_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        cfg_single_s && addr_s <= `AIS_LAST_SE_ADDR |=>
        vin_neg_ground_o && vin_pos_sel_o == $past(addr_s) && !addr_invalid_o)
        else $error("single-ended steering wrong");

    pseudo_mode_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        !cfg_single_s |=> input_mode_o == ($past(addr_s[0]) ? ais_mode_pseudo_diff
                                                            : ais_mode_full_diff))
        else $error("pseudo differential select wrong");

    coding_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        twos_complement_o == (input_mode_o == ais_mode_full_diff || range_high_o))
        else $error("output coding wrong");

    lsb_single_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        input_mode_o == ais_mode_single |-> lsb_shift_o == {1'b0, range_high_o})
        else $error("single-ended LSB wrong");

    lsb_diff_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        input_mode_o == ais_mode_full_diff |->
        lsb_shift_o == (range_high_o ? `AIS_SHIFT_DIFF_HIGH : `AIS_SHIFT_DIFF_LOW))
        else $error("differential LSB wrong");

    span_hold_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        phase_reg != ais_ph_track |=> $stable(range_lat_reg))
        else $error("span moved inside a frame");

    restart_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        phase_reg == ais_ph_convert && !cs_n_s && !track_back_s && mode_changed
        && cfg_single_s == cfg_single_reg |=> acq_restart_o && phase_reg == ais_ph_reacquire)
        else $error("mode change did not restart acquisition");

    corrupt_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        phase_reg == ais_ph_convert && cfg_single_s != cfg_single_reg |=>
        conv_corrupt_o && !acq_restart_o)
        else $error("config change mid-conversion not flagged");

    // ----------------------------------------
    // Scenario covers
    // ----------------------------------------
    full_frame_c: cover property (@(posedge clk_sys_i) disable iff (reset_i)
        phase_reg == ais_ph_convert ##1 phase_reg == ais_ph_track && track_back_s);
    restart_seen_c: cover property (@(posedge clk_sys_i) disable iff (reset_i)
        acq_restart_o);
    corrupt_seen_c: cover property (@(posedge clk_sys_i) disable iff (reset_i)
        conv_corrupt_o);
    high_span_diff_c: cover property (@(posedge clk_sys_i) disable iff (reset_i)
        input_mode_o == ais_mode_full_diff && range_high_o);

endmodule // ais_input_select

/* logic/ais_params.svh */
`ifndef AIS_PARAMS_SVH
`define AIS_PARAMS_SVH

// ----------------------------------------
// Link edge counting
// ----------------------------------------
// Serial clock rising edge, counted from select low, that ends the hold
`define AIS_TRACK_EDGE 4'hD
// Width of the link edge counter
`define AIS_CNT_W 4

// ----------------------------------------
// Channel address layout
// ----------------------------------------
// Width of one input index on either converter
`define AIS_SEL_W 3
// Highest valid single-ended address (input 6)
`define AIS_LAST_SE_ADDR 3'h5
// Highest valid differential pair index (pair 5/6)
`define AIS_LAST_PAIR 2'h2
// Index steered when the address is not decodable
`define AIS_SEL_IDLE 3'h0

// ----------------------------------------
// LSB size as a power of two times the reference over 4096
// ----------------------------------------
`define AIS_SHIFT_SE_LOW 2'h0
`define AIS_SHIFT_SE_HIGH 2'h1
`define AIS_SHIFT_DIFF_LOW 2'h1
`define AIS_SHIFT_DIFF_HIGH 2'h2

// ----------------------------------------
// Synchroniser reset images
// ----------------------------------------
// Chip select idles high, every other sampled pin idles low
`define AIS_SYNC_RESET 7'h40

`endif

/* logic/ais_pin_sync.sv */
`timescale 1ns/10ps

// Three-stage synchroniser; a bit moves only once stages two and three agree
module ais_pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // System clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // Asynchronous levels in
    input wire logic [WIDTH-1:0] async_i,
    // Filtered levels out
    output logic [WIDTH-1:0] sync_o
);

    // ----------------------------------------
    // Elaboration check
    // ----------------------------------------
    if (WIDTH < 1) begin : g_bad_width
        $error("ais_pin_sync needs at least one bit");
    end

    // ----------------------------------------
    // Stages
    // ----------------------------------------
    logic [WIDTH-1:0] stage1_reg; // Metastable catch, read only by stage2
    logic [WIDTH-1:0] stage2_reg; // First settled copy
    logic [WIDTH-1:0] stage3_reg; // Second settled copy
    logic [WIDTH-1:0] agree; // Bits where the settled copies match

    // Shift chain
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            stage1_reg <= RESET_VAL;
            stage2_reg <= RESET_VAL;
            stage3_reg <= RESET_VAL;
        end else begin
            stage1_reg <= async_i;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
        end
    end

    assign agree = ~(stage2_reg ^ stage3_reg);

    // Output takes a bit only when both settled copies agree; a one-cycle
    // glitch on a pin therefore never reaches the logic behind
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            sync_o <= RESET_VAL;
        end else begin
            sync_o <= (stage3_reg & agree) | (sync_o & ~agree);
        end
    end

endmodule // ais_pin_sync

/* logic/ais_pkg.sv */
package ais_pkg;

    // ----------------------------------------
    // Analog input wiring seen by both converters
    // ----------------------------------------
    typedef enum logic [1:0] {
        ais_mode_single,
        ais_mode_full_diff,
        ais_mode_pseudo_diff
    } ais_mode_t;

    // ----------------------------------------
    // Track-and-hold phase as seen from the system clock
    // ----------------------------------------
    typedef enum logic [1:0] {
        ais_ph_track,
        ais_ph_convert,
        ais_ph_reacquire
    } ais_phase_t;

endpackage

/* verif/adc_input_select_and_coding_test.sv */
`timescale 1ns/10ps

module adc_input_select_and_coding_test
    import ais_pkg::*;
;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic clk = 1'b0, rst = 1'b1, start = 1'b0, slow = 1'b0;
    logic cfg = 1'b0, a0 = 1'b0, a1 = 1'b0, a2 = 1'b0, rng = 1'b0;
    logic [4:0] edges = 5'h10;
    logic cs_n, sclk, busy;
    logic [4:0] edge_cnt;
    logic [2:0] pos, neg;
    logic gnd, inv, rhi, twos, track, restart, corrupt;
    logic [1:0] mode, lsb;
    int error_cnt = 0, checks = 0, seed = 32'h6a66, v, k;
    int restart_n = 0, corrupt_n = 0, cur_c, cur_a, cur_r;

    initial forever #20 clk = ~clk;

    ais_host_model host (.start_i(start), .edges_i(edges), .slow_i(slow), .cs_n_o(cs_n),
        .sclk_o(sclk), .busy_o(busy), .edge_cnt_o(edge_cnt));

    ais_input_select uut (.clk_sys_i(clk), .reset_i(rst), .converter_serial_clock_i(sclk),
        .cs_n_i(cs_n), .input_config_select_i(cfg), .channel_addr_bit0_i(a0),
        .channel_addr_bit1_i(a1), .channel_addr_bit2_i(a2), .range_select_i(rng),
        .vin_pos_sel_o(pos), .vin_neg_sel_o(neg), .vin_neg_ground_o(gnd),
        .addr_invalid_o(inv), .input_mode_o(mode), .range_high_o(rhi),
        .twos_complement_o(twos), .lsb_shift_o(lsb), .track_mode_o(track),
        .acq_restart_o(restart), .conv_corrupt_o(corrupt));

    // Count one-cycle status pulses
    always @(posedge clk) begin
        if (restart === 1'b1) restart_n++;
        if (corrupt === 1'b1) corrupt_n++;
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up;
        $display("errors %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // Pins change by NBA on the edge; held until changed again
    task automatic set_pins(input int c, input int a, input int r);
        @(posedge clk);
        cfg <= c[0]; a0 <= a[0]; a1 <= a[1]; a2 <= a[2]; rng <= r[0];
        cur_c = c; cur_a = a; cur_r = r;
    endtask

    // Filter plus register latency is 5 edges, 6 for span and coding; allow margin
    task automatic settle;
        repeat (8) @(posedge clk);
        #1;
    endtask

    // Reference decode of address, mode and coding
    task automatic check_all;
        int p, ep, en, em, eg, ei;
        p = cur_a >> 1;
        ep = 0; en = 0; eg = cur_c; ei = 0;
        em = cur_c ? ais_mode_single : (cur_a % 2 ? ais_mode_pseudo_diff : ais_mode_full_diff);
        if (cur_c && cur_a < 6) ep = cur_a;
        else if (!cur_c && p < 3) begin
            ep = 2 * p; en = 2 * p + 1;
        end else ei = 1;
        chk(8'(pos), 8'(ep));
        chk(8'(neg), 8'(en));
        chk(8'(gnd), 8'(eg));
        chk(8'(inv), 8'(ei));
        chk(8'(mode), 8'(em));
        chk(8'(rhi), 8'(cur_r));
        chk(8'(twos), 8'(!(em != ais_mode_full_diff && !cur_r)));
        chk(8'(lsb), 8'(em == ais_mode_full_diff ? cur_r + 1 : cur_r));
    endtask

    // Request one frame from the controller model
    task automatic frame(input logic sl);
        @(posedge clk);
        slow <= sl;
        @(posedge clk);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
    endtask

    task automatic wait_edges(input int n);
        for (k = 0; k < 3000 && edge_cnt < n; k++) @(posedge clk);
        #1;
        chk(8'(k < 3000), 8'h01);
    endtask

    task automatic wait_idle;
        for (k = 0; k < 3000 && busy !== 1'b0; k++) @(posedge clk);
        chk(8'(k < 3000), 8'h01);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (2) @(posedge clk);
        #1;
        chk(8'(track), 8'h01);
        chk(8'(mode), 8'(ais_mode_full_diff));
        chk(8'(pos), 8'h00);
        @(posedge clk);
        rst <= 1'b0;
        // Full sweep, then random picks
        for (int i = 0; i < 48; i++) begin
            v = (i < 32) ? i : $random(seed);
            set_pins(v[4], v[2:0], v[3]);
            settle;
            check_all;
        end
        // Frame with same-mode address move and span flip
        set_pins(0, 0, 1);
        settle;
        frame(1'b0);
        wait_edges(4);
        chk(8'(track), 8'h00);
        set_pins(0, 2, 0);
        settle;
        chk(8'(rhi), 8'h01);
        chk(8'(pos), 8'h02);
        wait_edges(12);
        chk(8'(track), 8'h00);
        wait_edges(13);
        for (k = 0; k < 10 && track !== 1'b1; k++) @(posedge clk);
        #1;
        chk(8'(track), 8'h01);
        chk(8'(cs_n), 8'h00);
        wait_idle;
        chk(8'(restart_n + corrupt_n), 8'h00);
        settle;
        check_all;
        // Full to pseudo mid-conversion restarts acquisition
        frame(1'b0);
        wait_edges(3);
        set_pins(0, 3, 0);
        settle;
        chk(8'(restart_n), 8'h01);
        chk(8'(track), 8'h01);
        chk(8'(corrupt_n), 8'h00);
        wait_idle;
        // Config flip mid-conversion, slow lead-in
        frame(1'b1);
        wait_edges(3);
        set_pins(1, 3, 0);
        settle;
        chk(8'(corrupt_n), 8'h01);
        chk(8'(restart_n), 8'h01);
        wait_idle;
        settle;
        check_all;
        // Cut frame: select rises before the counted edge, link clock then stops
        edges <= 5'h08;
        frame(1'b0);
        wait_edges(8);
        chk(8'(track), 8'h00);
        wait_idle;
        settle;
        chk(8'(track), 8'h01);
        chk(8'(restart_n + corrupt_n), 8'h02);
        wrap_up;
    end

    // Run is under a thousand cycles; cut off well beyond that
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        wrap_up;
    end
endmodule // adc_input_select_and_coding_test

/* verif/ais_host_model.sv */
`timescale 1ns/10ps

// Controller side: frames chip select and bursts the link clock
module ais_host_model (
    // Frame request from the bench
    input wire logic start_i,
    input wire logic [4:0] edges_i,
    input wire logic slow_i,
    // Link pins
    output logic cs_n_o,
    output logic sclk_o,
    // Progress seen by the bench
    output logic busy_o,
    output logic [4:0] edge_cnt_o
);
    // ----------------------------------------
    // Idle: select high, link clock parked low
    // ----------------------------------------
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        busy_o = 1'b0;
        edge_cnt_o = 5'h00;
    end

    // One frame per request; clock only runs inside it
    always @(posedge start_i) begin
        busy_o = 1'b1;
        edge_cnt_o = 5'h00;
        cs_n_o = 1'b0;
        // Slow answer stretches the lead-in before the first edge
        #(slow_i ? 1100 : 317);
        repeat (edges_i) begin
            #62.5 sclk_o = 1'b1;
            edge_cnt_o = edge_cnt_o + 5'h01;
            #62.5 sclk_o = 1'b0;
        end
        #200 cs_n_o = 1'b1;
        // Long quiet gap so the next frame starts clean
        #400 busy_o = 1'b0;
    end
endmodule // ais_host_model
